// [design/sgd_engine.sv]
// scatter/gather descriptor engine for seven dma channels
`timescale 1ns/1ps
module sgd_engine #(
  parameter int NCH        = sgd_pkg::NCH,
  parameter int FIFO_DEPTH = sgd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    dma_master_clear,
  // register port
  input  wire logic [15:0]             io_addr,
  input  wire logic                    io_wr,
  input  wire logic                    io_rd,
  input  wire logic [31:0]             io_wdata,
  output logic [31:0]                  io_rdata_q,
  output logic                         io_rvalid_q,
  // dma core
  input  wire logic [NCH-1:0]          dma_request,
  input  wire logic [NCH-1:0]          xfer_begin,
  input  wire logic [NCH-1:0]          term_count,
  output sgd_pkg::sgd_desc_t           cur_desc_q [NCH],
  output logic [NCH-1:0]               mask_set_q,
  output logic [NCH-1:0]               end_of_process_signal_q,
  output logic [NCH-1:0]               sg_term_q,
  output logic                         irq13_q,
  // descriptor memory read
  output logic                         mem_req_q,
  output logic [31:0]                  mem_addr_q,
  input  wire logic                    mem_gnt,
  input  wire logic [31:0]             mem_rdata,
  input  wire logic                    mem_rvalid
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic addr_in(input logic [15:0] a, input logic [15:0] b,
                                   input int lsb);
    addr_in = ((a >> lsb) == (b >> lsb));
  endfunction

  function automatic logic [2:0] first_one(input logic [NCH-1:0] v);
    first_one = 3'h0;
    for (int i = NCH-1; i >= 0; i--)
      if (v[i])
        first_one = 3'(i);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [NCH-1:0]     active_q;
  logic [NCH-1:0]     base_full_q;
  logic [NCH-1:0]     cur_full_q;
  logic [NCH-1:0]     eol_q;
  logic [NCH-1:0]     first_q;
  logic [NCH-1:0]     irq_sel_q;
  logic [NCH-1:0]     int_q;
  logic [31:0]        dtp_q [NCH];
  logic [31:0]        next_q [NCH];
  sgd_pkg::sgd_desc_t base_q [NCH];
  sgd_pkg::sgd_fetch_t state_q;
  logic [2:0]         sel_q;
  logic [31:0]        word0_q;

  // ****************************************************************
  // register decode
  // ****************************************************************
  wire              hit_int  = (io_addr == sgd_pkg::INT_SRC_OFS);
  wire              hit_cmd  = addr_in(io_addr, sgd_pkg::CMD_BASE, 3);
  wire              hit_stat = addr_in(io_addr, sgd_pkg::STAT_BASE, 3);
  wire              hit_dtp  = addr_in(io_addr, sgd_pkg::DTP_BASE, 5)
                               && (io_addr[1:0] == 2'h0);
  wire [NCH-1:0]    cmd_vec  = (io_wr && hit_cmd)
                               ? (8'h01 << io_addr[2:0]) & sgd_pkg::CH_EN_MASK : 8'h00;
  wire [NCH-1:0]    wr_dtp   = (io_wr && hit_dtp)
                               ? (8'h01 << io_addr[4:2]) & sgd_pkg::CH_EN_MASK : 8'h00;
  wire [NCH-1:0]    start    = cmd_vec & {NCH{io_wdata[1:0] == sgd_pkg::CMD_START}};
  wire [NCH-1:0]    stop     = cmd_vec & {NCH{io_wdata[1:0] == sgd_pkg::CMD_STOP}};
  wire [NCH-1:0]    sel_wr   = cmd_vec & {NCH{io_wdata[sgd_pkg::CMD_SELEN_BIT]}};
  wire [NCH-1:0]    mclr     = {NCH{dma_master_clear}};
  wire [7:0]        int_src  = int_q & sgd_pkg::INT_RSV_MASK;

  sgd_pkg::sgd_status_t st_rd;
  assign st_rd.end_of_list_flag       = eol_q[io_addr[2:0]];
  assign st_rd.rsv6      = 1'b0;
  assign st_rd.irq_sel   = irq_sel_q[io_addr[2:0]];
  assign st_rd.rsv4      = 1'b0;
  assign st_rd.base_full = base_full_q[io_addr[2:0]];
  assign st_rd.cur_full  = cur_full_q[io_addr[2:0]];
  assign st_rd.rsv1      = 1'b0;
  assign st_rd.active    = active_q[io_addr[2:0]];

  wire [31:0] rdata_d = hit_int  ? {24'h00_0000, int_src} :
                        hit_stat ? {24'h00_0000, st_rd} :
                        hit_dtp  ? dtp_q[io_addr[4:2]] : 32'h0000_0000;

  // ****************************************************************
  // buffer events
  // ****************************************************************
  wire [NCH-1:0] tcc  = term_count & cur_full_q;
  wire [NCH-1:0] xs   = xfer_begin & base_full_q & ~cur_full_q;
  wire [NCH-1:0] last = tcc & ~base_full_q & eol_q;

  // ****************************************************************
  // descriptor fetch
  // ****************************************************************
  logic          fifo_s_ready;
  logic          fifo_m_valid;
  logic [31:0]   fifo_m_data;
  wire           fifo_pop  = fifo_m_valid && ((state_q == sgd_pkg::F_W0)
                                              || (state_q == sgd_pkg::F_W1));
  // dma request wins within a channel; lowest channel wins across
  // request beats prefetch
  wire [NCH-1:0] need      = active_q & ~base_full_q & ~eol_q & ~dma_request;
  wire [2:0]     pick      = first_one(need);
  wire           launch    = (state_q == sgd_pkg::F_IDLE) && (|need)
                             && fifo_s_ready && !fifo_m_valid;
  wire [31:0]    fetch_adr = first_q[pick] ? dtp_q[pick] : next_q[pick];
  wire           fetch_end = (state_q == sgd_pkg::F_W1) && fifo_m_valid;
  wire [NCH-1:0] done      = fetch_end ? (8'h01 << sel_q) & active_q & ~start
                                       & ~stop & ~mclr : 8'h00;
  wire           new_eol   = fifo_m_data[sgd_pkg::DESC_EOL_BIT];

  sgd_fifo #(
    .WIDTH (sgd_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .s_valid (mem_rvalid),
    .s_ready (fifo_s_ready),
    .s_data  (mem_rdata),
    .m_valid (fifo_m_valid),
    .m_ready (fifo_pop),
    .m_data  (fifo_m_data)
  );

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= sgd_pkg::F_IDLE;
      sel_q      <= 3'h0;
      mem_req_q  <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
      word0_q    <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        sgd_pkg::F_IDLE:
          if (launch)
          begin
            sel_q      <= pick;
            mem_addr_q <= fetch_adr;
            mem_req_q  <= 1'b1;
            state_q    <= sgd_pkg::F_REQ;
          end
        sgd_pkg::F_REQ:
          if (mem_gnt)
          begin
            mem_req_q <= 1'b0;
            state_q   <= sgd_pkg::F_W0;
          end
        sgd_pkg::F_W0:
          if (fifo_m_valid)
          begin
            word0_q <= fifo_m_data;
            state_q <= sgd_pkg::F_W1;
          end
        sgd_pkg::F_W1:
          if (fifo_m_valid)
            state_q <= sgd_pkg::F_IDLE;
        default:
          state_q <= sgd_pkg::F_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // per-channel state
  // ****************************************************************
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        active_q[c]    <= 1'b0;
        base_full_q[c] <= 1'b0;
        cur_full_q[c]  <= 1'b0;
        eol_q[c]       <= 1'b0;
        first_q[c]     <= 1'b0;
        sg_term_q[c]   <= 1'b0;
      end
      else if (mclr[c] || start[c])
      begin
        active_q[c]    <= start[c];
        base_full_q[c] <= 1'b0;
        cur_full_q[c]  <= 1'b0;
        eol_q[c]       <= 1'b0;
        first_q[c]     <= start[c];
        sg_term_q[c]   <= 1'b0;
      end
      else
      begin
        if (stop[c] || last[c])
        begin
          active_q[c]  <= 1'b0;
          sg_term_q[c] <= 1'b1;
        end
        if (done[c])
          base_full_q[c] <= 1'b1;
        else if (xs[c])
          base_full_q[c] <= 1'b0;
        if (xs[c])
          cur_full_q[c] <= 1'b1;
        else if (tcc[c] || stop[c])
          cur_full_q[c] <= 1'b0;
        if (done[c])
        begin
          eol_q[c]   <= new_eol;
          first_q[c] <= 1'b0;
        end
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        irq_sel_q[c]               <= 1'b0;
        int_q[c]                   <= 1'b0;
        mask_set_q[c]              <= 1'b0;
        end_of_process_signal_q[c] <= 1'b0;
      end
      else
      begin
        if (mclr[c])
          irq_sel_q[c] <= 1'b0;
        else if (sel_wr[c])
          irq_sel_q[c] <= ~io_wdata[sgd_pkg::CMD_SEL_BIT];
        if (last[c] && irq_sel_q[c])
          int_q[c] <= 1'b1;
        else if (mclr[c] || start[c])
          int_q[c] <= 1'b0;
        mask_set_q[c]              <= stop[c];
        end_of_process_signal_q[c] <= (last[c] || stop[c]) && !irq_sel_q[c];
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        dtp_q[c]      <= sgd_pkg::DTP_RST;
        next_q[c]     <= sgd_pkg::DTP_RST;
        base_q[c]     <= '0;
        cur_desc_q[c] <= '0;
      end
      else
      begin
        if (wr_dtp[c])
          dtp_q[c] <= io_wdata;
        else if (tcc[c] && !eol_q[c])
          dtp_q[c] <= dtp_q[c] + sgd_pkg::DESC_STRIDE;
        if (done[c])
        begin
          base_q[c] <= '{addr: word0_q, cnt: {1'b0, fifo_m_data[30:0]}};
          if (!new_eol)
            next_q[c] <= mem_addr_q + sgd_pkg::DESC_STRIDE;
        end
        if (xs[c])
          cur_desc_q[c] <= base_q[c];
      end
    end

    AST_BASE_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      done[c] |=> base_full_q[c] ##1 base_full_q[c] || $past(xs[c]) || $past(start[c])
      || $past(mclr[c]))
      else $error("base flag not set after fetch");
    AST_BASE_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (tcc[c] && base_full_q[c] && !xs[c] && !mclr[c] && !start[c])
      |=> base_full_q[c] && !cur_full_q[c])
      else $error("base moved before transfer start");
    AST_CUR_MOVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (xs[c] && !mclr[c] && !start[c])
      |=> cur_full_q[c] && (cur_desc_q[c] == $past(base_q[c])))
      else $error("current not loaded from base");
    AST_ACT_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (start[c] && !mclr[c]) |=> active_q[c] && !eol_q[c] && !base_full_q[c])
      else $error("start did not set active");
    AST_ACT_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ((stop[c] || last[c] || mclr[c]) && !start[c]) |=> !active_q[c])
      else $error("active not cleared");
    AST_DTP_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (tcc[c] && !eol_q[c] && !wr_dtp[c]) |=> dtp_q[c] == $past(dtp_q[c]) + 32'h0000_0008)
      else $error("pointer not stepped by eight");
    AST_DTP_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_dtp[c] |=> dtp_q[c] == $past(io_wdata))
      else $error("pointer write lost");
    AST_EOL_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (done[c] && new_eol) |=> eol_q[c] && $stable(next_q[c]))
      else $error("end-of-list fetch replaced next value");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (last[c] && irq_sel_q[c]) |=> int_q[c] ##1 irq13_q)
      else $error("irq13 not raised on last terminal count");
    AST_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (stop[c] && !mclr[c]) |=> mask_set_q[c] && sg_term_q[c] && !active_q[c])
      else $error("stop did not terminate and mask");
  end

  AST_FIRST_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (launch && first_q[pick]) |=> mem_req_q && mem_addr_q == $past(dtp_q[pick]))
    else $error("first fetch not at table pointer");
  AST_PRIO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    launch |-> !dma_request[pick])
    else $error("prefetch issued over dma request");
  AST_SRC_RSV: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (io_rd && hit_int) |=> io_rvalid_q && io_rdata_q[4] == 1'b0)
    else $error("reserved source bit not zero");

  // ****************************************************************
  // read return and interrupt line
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_rdata_q  <= {24'h00_0000, sgd_pkg::INT_SRC_RST};
      io_rvalid_q <= 1'b0;
      irq13_q     <= 1'b0;
    end
    else
    begin
      io_rvalid_q <= io_rd;
      io_rdata_q  <= io_rd ? rdata_d : 32'h0000_0000;
      irq13_q     <= |int_src;
    end
  end

endmodule // sgd_engine

// [design/sgd_pkg.sv]
// constants, field layouts and types of the scatter/gather descriptor unit
package sgd_pkg;

  // ****************************************************************
  // channels
  // ****************************************************************
  localparam int NCH        = 8;
  localparam int ABSENT_CH  = 4;
  localparam logic [7:0] CH_EN_MASK = 8'hEF;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [15:0] INT_SRC_OFS = 16'h040A;
  localparam logic [15:0] CMD_BASE    = 16'h0410;
  localparam logic [15:0] STAT_BASE   = 16'h0418;
  localparam logic [15:0] DTP_BASE    = 16'h0420;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  INT_SRC_RST = 8'h00;
  localparam logic [7:0]  STAT_RST    = 8'h00;
  localparam logic [31:0] DTP_RST     = 32'h0000_0000;

  // ****************************************************************
  // field positions and codes
  // ****************************************************************
  localparam int CMD_SEL_BIT   = 7;
  localparam int CMD_SELEN_BIT = 6;
  localparam int DESC_EOL_BIT  = 31;
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_STOP  = 2'h2;
  localparam logic [7:0] INT_RSV_MASK = 8'hEF;

  // ****************************************************************
  // descriptor layout and buffering
  // ****************************************************************
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
  localparam int WORD_W     = 32;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] cnt;
  } sgd_desc_t;

  typedef struct packed {
    logic end_of_list_flag;
    logic rsv6;
    logic irq_sel;
    logic rsv4;
    logic base_full;
    logic cur_full;
    logic rsv1;
    logic active;
  } sgd_status_t;

  typedef enum logic [3:0] {
    F_IDLE = 4'h1,
    F_REQ  = 4'h2,
    F_W0   = 4'h4,
    F_W1   = 4'h8
  } sgd_fetch_t;

endpackage

// [design/sgd_fifo.sv]
// word fifo between the memory read return and the descriptor loader
`timescale 1ns/1ps
module sgd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             s_valid,
  output logic                  s_ready,
  input  wire logic [WIDTH-1:0] s_data,
  // drain side
  output logic                  m_valid,
  input  wire logic             m_ready,
  output logic [WIDTH-1:0]      m_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire              push = s_valid && s_ready;
  wire              pop  = m_valid && m_ready;

  assign s_ready = (cnt_q != (AW+1)'(DEPTH));
  assign m_valid = (cnt_q != '0);
  assign m_data  = mem_q[rp_q];

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_q[wp_q] <= s_data;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sgd_fifo

// [dv/sgd_mem_model.sv]
// descriptor memory model answering the engine's fetch requests
`timescale 1ns/1ps
module sgd_mem_model #(
  parameter logic [31:0] BUF_OFS = 32'h1000_0000
) (
  // clock
  input  wire logic        ref_clk,
  // fetch port
  input  wire logic        mem_req_q,
  input  wire logic [31:0] mem_addr_q,
  output logic             mem_gnt,
  output logic [31:0]      mem_rdata,
  output logic             mem_rvalid
);
  logic [31:0] a;

  // ****************************************************************
  // grant after a random wait, then two words after a random latency
  // ****************************************************************
  initial
  begin
    mem_gnt    = 1'b0;
    mem_rvalid = 1'b0;
    mem_rdata  = 32'h0000_0000;
    forever
    begin
      @(posedge ref_clk);
      if (mem_req_q === 1'b1)
      begin
        repeat ($urandom_range(0, 3)) @(posedge ref_clk);
        a = mem_addr_q;
        mem_gnt <= 1'b1;
        @(posedge ref_clk);
        mem_gnt <= 1'b0;
        repeat ($urandom_range(0, 4)) @(posedge ref_clk);
        mem_rvalid <= 1'b1;
        mem_rdata  <= a + BUF_OFS;
        @(posedge ref_clk);
        mem_rdata <= {a[3], 15'h0000, a[15:0]};
        @(posedge ref_clk);
        mem_rvalid <= 1'b0;
        mem_rdata  <= ~mem_rdata;
      end
    end
  end
endmodule // sgd_mem_model

// [dv/sgd_engine_tb_top.sv]
// self-checking bench of the descriptor engine with a memory model
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module sgd_engine_tb_top;
  localparam logic [31:0] OFS = 32'h1000_0000;
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               dma_master_clear = 1'b0;
  logic [15:0]        io_addr = 16'h0000;
  logic               io_wr = 1'b0;
  logic               io_rd = 1'b0;
  logic [31:0]        io_wdata = 32'h0000_0000;
  logic [31:0]        io_rdata_q;
  logic               io_rvalid_q;
  logic [7:0]         dma_request = 8'h00;
  logic [7:0]         xfer_begin = 8'h00;
  logic [7:0]         term_count = 8'h00;
  sgd_pkg::sgd_desc_t cur_desc_q [8];
  logic [7:0]         mask_set_q;
  logic [7:0]         end_of_process_signal_q;
  logic [7:0]         sg_term_q;
  logic               irq13_q;
  logic               mem_req_q;
  logic               mem_gnt;
  logic               mem_rvalid;
  logic               req_d = 1'b0;
  logic [31:0]        mem_addr_q;
  logic [31:0]        mem_rdata;
  logic [31:0]        p;
  logic [31:0]        e;
  logic [31:0]        m;
  logic [31:0]        ea;
  logic [31:0]        rq [$];
  logic [31:0]        mq [$];
  logic [31:0]        aq [$];
  int                 n_errors = 0;
  int                 checked = 0;
  int                 cyc = 0;

  always #2 ref_clk = ~ref_clk;

  sgd_engine #(.NCH(8), .FIFO_DEPTH(16)) u_dut (
    .ref_clk, .rst_n, .dma_master_clear, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata_q, .io_rvalid_q, .dma_request, .xfer_begin, .term_count, .cur_desc_q,
    .mask_set_q, .end_of_process_signal_q, .sg_term_q, .irq13_q, .mem_req_q,
    .mem_addr_q, .mem_gnt, .mem_rdata, .mem_rvalid
  );

  sgd_mem_model #(.BUF_OFS(OFS)) u_mem (
    .ref_clk, .mem_req_q, .mem_addr_q, .mem_gnt, .mem_rdata, .mem_rvalid
  );

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    io_wr    <= 1'b1;
    io_addr  <= a;
    io_wdata <= d;
    @(posedge ref_clk);
    io_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [31:0] k);
    rq.push_back(d);
    mq.push_back(k);
    @(posedge ref_clk);
    io_rd   <= 1'b1;
    io_addr <= a;
    @(posedge ref_clk);
    io_rd <= 1'b0;
  endtask

  task automatic ev(input logic [7:0] xb, input logic [7:0] tc);
    @(posedge ref_clk);
    xfer_begin <= xb;
    term_count <= tc;
    @(posedge ref_clk);
    xfer_begin <= 8'h00;
    term_count <= 8'h00;
    #1;
  endtask

  task automatic settle();
    repeat (30) @(posedge ref_clk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // output watcher and timeout
  // ****************************************************************
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    req_d <= mem_req_q;
    if (cyc > 5000)
    begin
      n_errors++;
      end_of_test();
    end
    if (io_rvalid_q === 1'b1)
    begin
      e = rq.pop_front();
      m = mq.pop_front();
      `CHK(io_rdata_q & m, e)
    end
    if (mem_req_q === 1'b1 && req_d !== 1'b1)
    begin
      ea = aq.pop_front();
      `CHK(mem_addr_q, ea)
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(49446));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(16'h040A, 32'h0000_0000, 32'h0000_00FF);
    rd(16'h0418, 32'h0000_0000, 32'h0000_00FF);
    done("reset");
    p = $urandom & 32'hFFFF_FFF0;
    wr(16'h0420, p);
    rd(16'h0420, p, 32'hFFFF_FFFF);
    wr(16'h0430, p);
    rd(16'h0430, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(16'h0500, 32'h0000_0000, 32'hFFFF_FFFF);
    done("pointer");
    dma_request <= 8'h01;
    aq.push_back(p);
    wr(16'h0410, 32'h0000_0041);
    repeat (10) @(posedge ref_clk);
    `CHK(mem_req_q, 1'b0)
    dma_request <= 8'h00;
    settle();
    `CHK(irq13_q, 1'b0)
    rd(16'h0418, 32'h0000_0029, 32'h0000_00FF);
    aq.push_back(p + 32'h0000_0008);
    ev(8'h01, 8'h00);
    `CHK(cur_desc_q[0].addr, p + OFS)
    settle();
    rd(16'h0418, 32'h0000_00AD, 32'h0000_00FF);
    ev(8'h00, 8'h01);
    rd(16'h0418, 32'h0000_00A9, 32'h0000_00FF);
    ev(8'h01, 8'h00);
    `CHK(cur_desc_q[0].addr, p + 32'h0000_0008 + OFS)
    `CHK(cur_desc_q[0].cnt[15:0], p[15:0] + 16'h0008)
    rd(16'h0418, 32'h0000_00A5, 32'h0000_00FF);
    ev(8'h00, 8'h01);
    repeat (3) @(posedge ref_clk);
    `CHK(irq13_q, 1'b1)
    rd(16'h040A, 32'h0000_0001, 32'h0000_00FF);
    rd(16'h0418, 32'h0000_00A0, 32'h0000_00FF);
    done("chain");
    p = p + 32'h0000_0100;
    wr(16'h043C, p);
    aq.push_back(p);
    wr(16'h0417, 32'h0000_00C1);
    settle();
    rd(16'h041F, 32'h0000_0009, 32'h0000_00FF);
    aq.push_back(p + 32'h0000_0008);
    ev(8'h80, 8'h00);
    `CHK(cur_desc_q[7].addr, p + OFS)
    ev(8'h00, 8'h80);
    settle();
    rd(16'h043C, p + 32'h0000_0008, 32'hFFFF_FFFF);
    rd(16'h041F, 32'h0000_0089, 32'h0000_00FF);
    wr(16'h0417, 32'h0000_0002);
    #1;
    `CHK(mask_set_q, 8'h80)
    `CHK(end_of_process_signal_q, 8'h80)
    `CHK(sg_term_q[7], 1'b1)
    rd(16'h041F, 32'h0000_0000, 32'h0000_0001);
    @(posedge ref_clk);
    dma_master_clear <= 1'b1;
    @(posedge ref_clk);
    dma_master_clear <= 1'b0;
    rd(16'h040A, 32'h0000_0000, 32'h0000_00FF);
    rd(16'h0418, 32'h0000_0000, 32'h0000_00FF);
    repeat (4) @(posedge ref_clk);
    `CHK(irq13_q, 1'b0)
    done("stop");
    end_of_test();
  end
endmodule // sgd_engine_tb_top
